// ===== core/gpib_port_pkg.sv
// constants, field layouts and types shared by the trace and status port
// assumes an apb master on the register side and a gpib bus on the pin side
package gpib_port_pkg;

  // ==================================================================
  // register map
  localparam logic [11:0] CTRL_OFS       = 12'h000;
  localparam logic [11:0] STAT_OFS       = 12'h004;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam int          CTRL_KEYSRQ    = 0;
  localparam int          CTRL_ADDR_LSB  = 8;
  localparam int          ADDR_W         = 5;
  localparam int          STAT_TALK      = 8;
  localparam int          STAT_LISTEN    = 9;
  localparam int          STAT_SPM       = 10;
  localparam int          STAT_LOAD      = 11;
  localparam int          STAT_UNLOAD    = 12;
  localparam int          STAT_VIS       = 13;

  // ==================================================================
  // bus commands and characters
  localparam logic [6:0] CMD_SPE    = 7'h18;
  localparam logic [6:0] CMD_SPD    = 7'h19;
  localparam logic [6:0] CMD_UNL    = 7'h3f;
  localparam logic [6:0] CMD_UNT    = 7'h5f;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK   = 2'h2;
  localparam logic [7:0] CH_A       = 8'h41;
  localparam logic [7:0] CH_B       = 8'h42;
  localparam logic [7:0] CH_I       = 8'h49;
  localparam logic [7:0] CH_O       = 8'h4f;
  localparam logic [7:0] CH_CR      = 8'h0d;
  localparam logic [7:0] CH_LF      = 8'h0a;

  // ==================================================================
  // trace word format
  localparam int          TRACE_BYTES = 2004;
  localparam logic [10:0] TRACE_LAST  = 11'(TRACE_BYTES - 1);
  localparam int          MAG_W       = 10;
  localparam logic [9:0]  MAG_TOP     = 10'h3ff;
  localparam logic [9:0]  MAG_REF     = 10'h3e8;
  localparam int          UNBLANK_BIT = 12;
  localparam int          BLANK_BIT   = 13;
  localparam logic [7:0]  HEAD_BYTE   = 8'hff;

  // ==================================================================
  // status byte bits and handshake states
  localparam int ST_BADCMD = 0;
  localparam int ST_TRIG   = 1;
  localparam int ST_KEY    = 2;
  localparam int ST_RQS    = 6;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_TDAV  = 2'b01,
    HS_TEND  = 2'b11,
    HS_LWAIT = 2'b10
  } hs_e;

  // ==================================================================
  // port state
  typedef struct packed {
    logic [1:0]        atn_s;
    logic [1:0]        dav_s;
    logic [1:0]        nrfd_s;
    logic [1:0]        ndac_s;
    logic [7:0]        dio_s1;
    logic [7:0]        dio_s2;
    hs_e               hs;
    logic              talk;
    logic              listen;
    logic              spm;
    logic [2:0]        cause;
    logic              rqs;
    logic              key_mode;
    logic [ADDR_W-1:0] bus_addr;
    logic [7:0]        prev_ch;
    logic              have_ch;
    logic              load_act;
    logic              load_b;
    logic              skip_eol;
    logic [10:0]       cnt;
    logic [7:0]        hi;
    logic              vis;
    logic              unload;
    logic [10:0]       ucnt;
    logic              uvis;
    logic [7:0]        tx;
    logic              wr;
    logic              wr_b;
    logic [9:0]        wr_idx;
    logic [MAG_W-1:0]  wr_mag;
    logic              wr_vis;
    logic              wr_ref;
    logic [31:0]       prdata;
  } st_s;

endpackage

// ===== core/gpib_trace_and_status_port.sv
// gpib trace load/unload and service request logic with an apb register file
// assumes bus lines given as logical levels (1 = true) and a display memory
// on pclk with a combinational read port
// Contract
// - trace word bits 0..9 are an unsigned magnitude, 0 bottom, 1023 top.
// - reference level corresponds to magnitude 1000.
// - bits 10, 11, 14 and 15 of a trace word are ignored.
// - bit 12 set makes this and following segments visible.
// - once visible, further bit 12 has no effect until bit 13 arrives.
// - bit 13 set hides this and following segments.
// - visibility change starts at the magnitude in the same word.
// - unload command sends 2004 bytes of trace B when talk addressed.
// - an unloaded byte stream reloaded unchanged reproduces the trace.
// - trace A load works like trace B load but writes trace A.
// - an uninterpretable command raises a service request.
// - a settled delayed trigger with data ready raises a service request.
// - key press in key entry service request mode raises a request.
// - serial poll: SPE, talk address, status byte, then SPD.
// - SPD withdraws the request and clears status bits 0..2 and 6.
// - status bit 6 shows own request, bit 7 carries nothing.
// - load is 1002 words from 2004 bytes; leading all-ones word not shown.
// - after a load command skip CR/LF, take binary, then return to ascii.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps

module gpib_trace_and_status_port
  import gpib_port_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [7:0]         dio_in,
  output logic      [7:0]         dio_out,
  output logic                    dio_oe,
  input  wire logic               atn_in,
  input  wire logic               dav_in,
  output logic                    dav_out,
  output logic                    dav_oe,
  input  wire logic               nrfd_in,
  output logic                    nrfd_out,
  output logic                    nrfd_oe,
  input  wire logic               ndac_in,
  output logic                    ndac_out,
  output logic                    ndac_oe,
  output logic                    srq_out,
  output logic                    srq_oe,
  input  wire logic               settled_trigger_ready,
  input  wire logic               key_pressed,
  input  wire logic [2:0]         status_aux,
  output logic                    trace_wr,
  output logic                    trace_wr_sel_b,
  output logic      [9:0]         trace_wr_index,
  output logic      [MAG_W-1:0]   trace_wr_mag,
  output logic                    trace_wr_visible,
  output logic                    trace_wr_above_ref,
  output logic      [9:0]         trace_rd_index,
  input  wire logic [MAG_W-1:0]   trace_rd_mag,
  input  wire logic               trace_rd_visible
);

  // ==================================================================
  // state
  st_s s_r;
  st_s s_nxt;

  logic        atn;
  logic        dav;
  logic        nrfd;
  logic        ndac;
  logic        lsn_act;
  logic        accept;
  logic        start_tx;
  logic        done_tx;
  logic [6:0]  cmd;
  logic [15:0] word;
  logic [9:0]  widx;
  logic        word_ev;
  logic        bad_cmd;
  logic        spd_ev;
  logic [2:0]  cause_set;
  logic [9:0]  ridx;
  logic [7:0]  tx_byte;
  logic        hit;
  logic [7:0]  stat_byte;

  assign atn  = s_r.atn_s[1];
  assign dav  = s_r.dav_s[1];
  assign nrfd = s_r.nrfd_s[1];
  assign ndac = s_r.ndac_s[1];

  // ==================================================================
  // handshake and decode terms
  assign lsn_act  = atn | s_r.listen;
  assign accept   = (s_r.hs == HS_IDLE) && lsn_act && dav;
  assign cmd      = s_r.dio_s2[6:0];
  assign spd_ev   = accept && atn && (cmd == CMD_SPD);
  assign word     = {s_r.hi, s_r.dio_s2};
  assign widx     = s_r.cnt[10:1];
  assign word_ev  = accept && !atn && s_r.listen && s_r.load_act && s_r.cnt[0] &&
                    !(s_r.skip_eol && (s_r.dio_s2 == CH_CR || s_r.dio_s2 == CH_LF));
  assign bad_cmd  = accept && !atn && s_r.listen && !s_r.load_act && s_r.have_ch &&
                    !({s_r.prev_ch, s_r.dio_s2} inside {{CH_B, CH_I}, {CH_A, CH_I},
                                                       {CH_B, CH_O}});
  assign cause_set = {key_pressed & s_r.key_mode, settled_trigger_ready, bad_cmd};
  assign stat_byte = {1'b0, s_r.rqs, status_aux, s_r.cause};
  assign start_tx = (s_r.hs == HS_IDLE) && s_r.talk && !atn && (s_r.spm || s_r.unload) &&
                    !nrfd && ndac;
  assign done_tx  = (s_r.hs == HS_TDAV) && !atn && !ndac;
  assign ridx     = s_r.ucnt[10:1];
  assign trace_rd_index = (ridx == 10'h000) ? 10'h000 : 10'(ridx - 10'h001);

  // unload bytes carry visibility edges so a reload reproduces the trace
  always_comb begin
    if (s_r.spm) begin
      tx_byte = stat_byte;
    end else if (ridx == 10'h000) begin
      tx_byte = HEAD_BYTE;
    end else if (!s_r.ucnt[0]) begin
      tx_byte = {2'b00, s_r.uvis & ~trace_rd_visible, ~s_r.uvis & trace_rd_visible,
                 2'b00, trace_rd_mag[9:8]};
    end else begin
      tx_byte = trace_rd_mag[7:0];
    end
  end

  assign hit = (paddr == CTRL_OFS) || (paddr == STAT_OFS);

  // ==================================================================
  // next state
  always_comb begin
    s_nxt        = s_r;
    s_nxt.atn_s  = {s_r.atn_s[0], atn_in};
    s_nxt.dav_s  = {s_r.dav_s[0], dav_in};
    s_nxt.nrfd_s = {s_r.nrfd_s[0], nrfd_in};
    s_nxt.ndac_s = {s_r.ndac_s[0], ndac_in};
    s_nxt.dio_s1 = dio_in;
    s_nxt.dio_s2 = s_r.dio_s1;
    s_nxt.wr     = 1'b0;

    // apb register file
    if (psel && !penable && !pwrite) begin
      s_nxt.prdata = 32'h0000_0000;
      if (paddr == CTRL_OFS) begin
        s_nxt.prdata[CTRL_KEYSRQ] = s_r.key_mode;
        s_nxt.prdata[CTRL_ADDR_LSB +: ADDR_W] = s_r.bus_addr;
      end else if (paddr == STAT_OFS) begin
        s_nxt.prdata[7:0]         = stat_byte;
        s_nxt.prdata[STAT_TALK]   = s_r.talk;
        s_nxt.prdata[STAT_LISTEN] = s_r.listen;
        s_nxt.prdata[STAT_SPM]    = s_r.spm;
        s_nxt.prdata[STAT_LOAD]   = s_r.load_act;
        s_nxt.prdata[STAT_UNLOAD] = s_r.unload;
        s_nxt.prdata[STAT_VIS]    = s_r.vis;
      end
    end
    if (psel && penable && pwrite && (paddr == CTRL_OFS)) begin
      s_nxt.key_mode = pwdata[CTRL_KEYSRQ];
      s_nxt.bus_addr = pwdata[CTRL_ADDR_LSB +: ADDR_W];
    end

    // service request: a new cause wins over a clearing poll
    s_nxt.cause = (spd_ev ? 3'h0 : s_r.cause) | cause_set;
    s_nxt.rqs   = (spd_ev ? 1'b0 : s_r.rqs) | (|cause_set);

    // acceptor and source handshake, then command and data decode
    case (s_r.hs)
      HS_IDLE: begin
        if (accept) begin
          s_nxt.hs = HS_LWAIT;
        end else if (start_tx) begin
          s_nxt.tx = tx_byte;
          s_nxt.hs = HS_TDAV;
        end
      end
      HS_LWAIT: begin
        if (!dav) begin
          s_nxt.hs = HS_IDLE;
        end
      end
      HS_TDAV: begin
        if (atn) begin
          s_nxt.hs = HS_IDLE;
        end else if (!ndac) begin
          s_nxt.hs = HS_TEND;
        end
      end
      HS_TEND: begin
        if (ndac || atn) begin
          s_nxt.hs = HS_IDLE;
        end
      end
      default: begin
        s_nxt.hs = HS_IDLE;
      end
    endcase

    if (accept && atn) begin
      if (cmd == CMD_SPE) begin
        s_nxt.spm = 1'b1;
      end else if (cmd == CMD_SPD) begin
        s_nxt.spm = 1'b0;
      end else if (cmd == CMD_UNL) begin
        s_nxt.listen = 1'b0;
      end else if (cmd == CMD_UNT) begin
        s_nxt.talk = 1'b0;
      end else if (cmd[6:5] == GRP_LISTEN && cmd[4:0] == s_r.bus_addr) begin
        s_nxt.listen = 1'b1;
      end else if (cmd[6:5] == GRP_TALK) begin
        s_nxt.talk = (cmd[4:0] == s_r.bus_addr);
      end
    end else if (accept && s_r.listen) begin
      if (s_r.load_act) begin
        if (!(s_r.skip_eol && (s_r.dio_s2 == CH_CR || s_r.dio_s2 == CH_LF))) begin
          s_nxt.skip_eol = 1'b0;
          s_nxt.cnt      = 11'(s_r.cnt + 11'h001);
          if (!s_r.cnt[0]) begin
            s_nxt.hi = s_r.dio_s2;
          end
          if (s_r.cnt == TRACE_LAST) begin
            s_nxt.load_act = 1'b0;
          end
          if (word_ev && widx != 10'h000) begin
            // bits 10, 11, 14, 15 never looked at; blank beats unblank
            if (word[BLANK_BIT]) begin
              s_nxt.vis = 1'b0;
            end else if (word[UNBLANK_BIT]) begin
              s_nxt.vis = 1'b1;
            end
            s_nxt.wr     = 1'b1;
            s_nxt.wr_b   = s_r.load_b;
            s_nxt.wr_idx = 10'(widx - 10'h001);
            s_nxt.wr_mag = word[MAG_W-1:0];
            s_nxt.wr_vis = s_nxt.vis;
            s_nxt.wr_ref = (word[MAG_W-1:0] >= MAG_REF);
          end
        end
      end else if (s_r.have_ch) begin
        s_nxt.have_ch = 1'b0;
        if ({s_r.prev_ch, s_r.dio_s2} == {CH_B, CH_I} ||
            {s_r.prev_ch, s_r.dio_s2} == {CH_A, CH_I}) begin
          s_nxt.load_act = 1'b1;
          s_nxt.load_b   = (s_r.prev_ch == CH_B);
          s_nxt.skip_eol = 1'b1;
          s_nxt.cnt      = 11'h000;
          s_nxt.vis      = 1'b1;
        end else if ({s_r.prev_ch, s_r.dio_s2} == {CH_B, CH_O}) begin
          s_nxt.unload = 1'b1;
          s_nxt.ucnt   = 11'h000;
          s_nxt.uvis   = 1'b1;
        end
      end else if (s_r.dio_s2 != CH_CR && s_r.dio_s2 != CH_LF) begin
        s_nxt.prev_ch = s_r.dio_s2;
        s_nxt.have_ch = 1'b1;
      end
    end

    // source side bookkeeping once all listeners took the byte
    if (done_tx && !s_r.spm && s_r.unload) begin
      s_nxt.ucnt = 11'(s_r.ucnt + 11'h001);
      if (s_r.ucnt[0] && ridx != 10'h000) begin
        s_nxt.uvis = trace_rd_visible;
      end
      if (s_r.ucnt == TRACE_LAST) begin
        s_nxt.unload = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r          <= '0;
      s_r.hs       <= HS_IDLE;
      s_r.key_mode <= CTRL_RST[CTRL_KEYSRQ];
      s_r.bus_addr <= CTRL_RST[CTRL_ADDR_LSB +: ADDR_W];
      s_r.vis      <= 1'b1;
      s_r.uvis     <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==================================================================
  // outputs
  assign prdata             = s_r.prdata;
  assign pready             = 1'b1;
  assign pslverr            = psel && penable && !hit;
  assign dio_out            = s_r.tx;
  assign dio_oe             = (s_r.hs == HS_TDAV);
  assign dav_out            = 1'b1;
  assign dav_oe             = (s_r.hs == HS_TDAV);
  assign nrfd_out           = 1'b1;
  assign nrfd_oe            = lsn_act && (s_r.hs == HS_LWAIT);
  assign ndac_out           = 1'b1;
  assign ndac_oe            = lsn_act && (s_r.hs != HS_LWAIT) && (s_r.hs != HS_TDAV);
  assign srq_out            = 1'b1;
  assign srq_oe             = s_r.rqs;
  assign trace_wr           = s_r.wr;
  assign trace_wr_sel_b     = s_r.wr_b;
  assign trace_wr_index     = s_r.wr_idx;
  assign trace_wr_mag       = s_r.wr_mag;
  assign trace_wr_visible   = s_r.wr_vis;
  assign trace_wr_above_ref = s_r.wr_ref;

  // ==================================================================
  // checks
  chk_mag_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (word_ev && widx != 10'h000) |=> trace_wr && trace_wr_mag == $past(word[9:0]) &&
    trace_wr_mag <= MAG_TOP)
    else $error("magnitude not passed through");
  chk_blank_now: assert property (@(posedge pclk) disable iff (!presetn)
    (word_ev && widx != 10'h000 && word[BLANK_BIT]) |=> trace_wr && !trace_wr_visible)
    else $error("blank word drawn visible");
  chk_unblank_now: assert property (@(posedge pclk) disable iff (!presetn)
    (word_ev && widx != 10'h000 && word[UNBLANK_BIT] && !word[BLANK_BIT]) |=>
    trace_wr_visible)
    else $error("unblank word drawn hidden");
  chk_srq_badcmd: assert property (@(posedge pclk) disable iff (!presetn)
    bad_cmd |=> srq_oe && stat_byte[ST_BADCMD])
    else $error("bad command raised no request");
  chk_srq_trig: assert property (@(posedge pclk) disable iff (!presetn)
    settled_trigger_ready |=> srq_oe && stat_byte[ST_TRIG])
    else $error("trigger raised no request");
  chk_srq_key: assert property (@(posedge pclk) disable iff (!presetn)
    (key_pressed && s_r.key_mode) |=> srq_oe && stat_byte[ST_KEY])
    else $error("key raised no request");
  chk_spd_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (spd_ev && cause_set == 3'h0) |=> !srq_oe && s_r.cause == 3'h0 && !s_r.spm)
    else $error("poll disable did not clear");
  chk_poll_byte: assert property (@(posedge pclk) disable iff (!presetn)
    (start_tx && s_r.spm) |=> dio_oe && dio_out[ST_RQS] == $past(s_r.rqs) && !dio_out[7])
    else $error("status byte wrong");
  chk_load_len: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(s_r.load_act) |-> $past(s_r.cnt) == TRACE_LAST)
    else $error("load ended at wrong count");
  chk_unload_len: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(s_r.unload) && !$past(spd_ev) |-> $past(s_r.ucnt) == TRACE_LAST)
    else $error("unload ended at wrong count");

  cov_poll: cover property (@(posedge pclk) disable iff (!presetn) done_tx && s_r.spm);
  cov_load: cover property (@(posedge pclk) disable iff (!presetn) $fell(s_r.load_act));
  cov_unload: cover property (@(posedge pclk) disable iff (!presetn) $fell(s_r.unload));

endmodule

// ===== tb/gpib_ctrl_model.sv
// gpib system controller model: sends commands and data, listens to the device
// assumes device oe outputs mean line true and all lines are logical levels
`timescale 1ns/1ps
module gpib_ctrl_model (
  input  wire logic       pclk,
  input  wire logic [7:0] dio_out,
  input  wire logic       dio_oe,
  input  wire logic       dav_oe,
  input  wire logic       nrfd_oe,
  input  wire logic       ndac_oe,
  output wire logic [7:0] dio_in,
  output wire logic       atn_in,
  output wire logic       dav_in,
  output wire logic       nrfd_in,
  output wire logic       ndac_in
);
  logic [7:0] dio_r  = 8'h00;
  logic       atn_r  = 1'b0;
  logic       dav_r  = 1'b0;
  logic       nrfd_r = 1'b1;
  logic       ndac_r = 1'b1;
  // ==================================================================
  // wired-or lines; released data lines show the inverse of the last byte
  assign dio_in  = dio_oe ? dio_out : dio_r;
  assign atn_in  = atn_r;
  assign dav_in  = dav_r | dav_oe;
  assign nrfd_in = nrfd_r | nrfd_oe;
  assign ndac_in = ndac_r | ndac_oe;
  // no sweep or calibration is ever requested from here
  task automatic atn(input logic v);
    @(posedge pclk);
    atn_r <= v;
    repeat (3) @(posedge pclk);
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge pclk);
    nrfd_r <= 1'b0;
    ndac_r <= 1'b0;
    dio_r  <= b;
    @(posedge pclk);
    while (nrfd_in) @(posedge pclk);
    dav_r <= 1'b1;
    while (ndac_in) @(posedge pclk);
    dav_r <= 1'b0;
    dio_r <= ~b;
    @(posedge pclk);
    while (nrfd_oe) @(posedge pclk);
  endtask
  task automatic recv(output logic [7:0] b);
    @(posedge pclk);
    nrfd_r <= 1'b0;
    ndac_r <= 1'b1;
    while (!dav_in) @(posedge pclk);
    b = dio_in;
    nrfd_r <= 1'b1;
    @(posedge pclk);
    ndac_r <= 1'b0;
    while (dav_in) @(posedge pclk);
    ndac_r <= 1'b1;
  endtask
endmodule

// ===== tb/gpib_trace_and_status_port_bench.sv
// self-checking bench for the gpib trace and status port
// assumes gpib_ctrl_model as bus partner and keeps the display memory here
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); \
  end \
end
module gpib_trace_and_status_port_bench;
  import gpib_port_pkg::*;
  localparam logic [4:0] ADR = 5'h05;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, err, trig = 1'b0, key = 1'b0;
  logic [2:0]  aux = 3'h0;
  logic [7:0]  dio_in, dio_out, rx [0:2003];
  logic        dio_oe, atn_in, dav_in, dav_out, dav_oe, nrfd_in, nrfd_out, nrfd_oe;
  logic        ndac_in, ndac_out, ndac_oe, srq_out, srq_oe, trace_wr, trace_wr_sel_b;
  logic        trace_wr_visible, trace_wr_above_ref, trace_rd_visible;
  logic [9:0]  trace_wr_index, trace_wr_mag, trace_rd_index, trace_rd_mag;
  logic [9:0]  mem_mag [0:1023], exp_mag [0:1000];
  logic        mem_vis [0:1023], exp_vis [0:1000];
  logic [22:0] wq [$];
  int          mismatches = 0, checked = 0, cycles = 0;
  integer      seed = 69655;

  assign trace_rd_mag     = mem_mag[trace_rd_index];
  assign trace_rd_visible = mem_vis[trace_rd_index];

  initial forever #4 pclk = ~pclk;

  gpib_trace_and_status_port u_gpib_trace_and_status_port (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe), .atn_in(atn_in), .dav_in(dav_in),
    .dav_out(dav_out), .dav_oe(dav_oe), .nrfd_in(nrfd_in), .nrfd_out(nrfd_out),
    .nrfd_oe(nrfd_oe), .ndac_in(ndac_in), .ndac_out(ndac_out), .ndac_oe(ndac_oe),
    .srq_out(srq_out), .srq_oe(srq_oe), .settled_trigger_ready(trig), .key_pressed(key),
    .status_aux(aux), .trace_wr(trace_wr), .trace_wr_sel_b(trace_wr_sel_b),
    .trace_wr_index(trace_wr_index), .trace_wr_mag(trace_wr_mag),
    .trace_wr_visible(trace_wr_visible), .trace_wr_above_ref(trace_wr_above_ref),
    .trace_rd_index(trace_rd_index), .trace_rd_mag(trace_rd_mag),
    .trace_rd_visible(trace_rd_visible));

  gpib_ctrl_model u_ctrl (
    .pclk(pclk), .dio_out(dio_out), .dio_oe(dio_oe), .dav_oe(dav_oe), .nrfd_oe(nrfd_oe),
    .ndac_oe(ndac_oe), .dio_in(dio_in), .atn_in(atn_in), .dav_in(dav_in),
    .nrfd_in(nrfd_in), .ndac_in(ndac_in));

  // ==================================================================
  // verdict, timeout and trace write monitor
  task automatic stop_test();
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 95000) begin
      mismatches++;
      stop_test();
    end
  end

  always @(negedge pclk) begin
    if (trace_wr === 1'b1) begin
      if (wq.size() == 0) `CHECK("spare write", 1'b0, 1'b1)
      else `CHECK("trace write", wq.pop_front(), {trace_wr_sel_b, trace_wr_index,
        trace_wr_mag, trace_wr_visible, trace_wr_above_ref})
      if (trace_wr_sel_b === 1'b1) begin
        mem_mag[trace_wr_index] = trace_wr_mag;
        mem_vis[trace_wr_index] = trace_wr_visible;
      end
    end
  end

  // ==================================================================
  // bus tasks
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] b);
    u_ctrl.atn(1'b1);
    u_ctrl.send(b);
    u_ctrl.atn(1'b0);
  endtask

  task automatic load(input logic sel_b, input logic from_rx);
    logic [15:0] w;
    logic        vis;
    int          k;
    vis = 1'b1;
    cmd({1'b0, GRP_LISTEN, ADR});
    u_ctrl.send(sel_b ? CH_B : CH_A);
    u_ctrl.send(CH_I);
    u_ctrl.send(sel_b ? CH_CR : CH_LF);
    u_ctrl.send(from_rx ? rx[0] : HEAD_BYTE);
    u_ctrl.send(from_rx ? rx[1] : HEAD_BYTE);
    for (k = 0; k <= 1000; k++) begin
      w = 16'($random(seed));
      w[13:12] = (w[3:0] == 4'h0) ? 2'b10 : (w[3:0] == 4'h1) ? 2'b01 : 2'b00;
      case (k)
        0: w[9:0] = 10'h000;
        1: w[9:0] = MAG_TOP;
        2: w[9:0] = MAG_REF;
        3: w[9:0] = MAG_REF - 10'h001;
        5: w[13:12] = 2'b10;
        6, 7: w[13:12] = 2'b01;
        default: ;
      endcase
      if (from_rx) w = {rx[2*k+2], rx[2*k+3]};
      vis = w[13] ? 1'b0 : w[12] ? 1'b1 : vis;
      if (from_rx) `CHECK("reload point", {exp_mag[k], exp_vis[k]}, {w[9:0], vis})
      if (sel_b) begin
        exp_mag[k] = w[9:0];
        exp_vis[k] = vis;
      end
      wq.push_back({sel_b, k[9:0], w[9:0], vis, w[9:0] >= MAG_REF});
      u_ctrl.send(w[15:8]);
      u_ctrl.send(w[7:0]);
    end
    repeat (20) @(posedge pclk);
    `CHECK("writes left", 0, wq.size())
    cmd({1'b0, CMD_UNL});
  endtask

  task automatic unload();
    logic [7:0] b;
    logic [7:0] e;
    logic       vis;
    int         k;
    vis = 1'b1;
    cmd({1'b0, GRP_LISTEN, ADR});
    u_ctrl.send(CH_B);
    u_ctrl.send(CH_O);
    cmd({1'b0, CMD_UNL});
    cmd({1'b0, GRP_TALK, ADR});
    for (k = 0; k < TRACE_BYTES; k++) begin
      e = HEAD_BYTE;
      if (k >= 2 && k[0]) e = exp_mag[k/2-1][7:0];
      else if (k >= 2) begin
        e = {2'b00, vis & ~exp_vis[k/2-1], ~vis & exp_vis[k/2-1], 2'b00, exp_mag[k/2-1][9:8]};
        vis = exp_vis[k/2-1];
      end
      u_ctrl.recv(b);
      rx[k] = b;
      `CHECK("unload byte", e, b)
    end
    cmd({1'b0, CMD_UNT});
  endtask

  task automatic poll(input logic [2:0] cause);
    logic [7:0] b;
    int         k;
    for (k = 0; k < 50 && srq_oe !== 1'b1; k++) @(posedge pclk);
    `CHECK("srq raised", 1'b1, srq_oe)
    cmd({1'b0, CMD_SPE});
    cmd({1'b0, GRP_TALK, ADR});
    u_ctrl.recv(b);
    `CHECK("status byte", {2'b01, aux, cause}, b)
    cmd({1'b0, CMD_SPD});
    cmd({1'b0, CMD_UNT});
    `CHECK("srq withdrawn", 1'b0, srq_oe)
    apb(1'b0, STAT_OFS, 32'h0);
    `CHECK("cleared causes", 4'h0, {q[6], q[2:0]})
  endtask

  // ==================================================================
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    aux <= 3'($random(seed));
    apb(1'b1, CTRL_OFS, 32'(ADR) << CTRL_ADDR_LSB);
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHECK("ctrl readback", 32'(ADR) << CTRL_ADDR_LSB, q)
    apb(1'b0, 12'h008, 32'h0);
    `CHECK("unmapped", 33'h1_0000_0000, {err, q})
    apb(1'b1, STAT_OFS, 32'hffff_ffff);
    apb(1'b0, STAT_OFS, 32'h0);
    `CHECK("idle status", {18'h0, 1'b1, 5'h0, 2'b00, aux, 3'b000}, q)
    load(1'b1, 1'b0);
    unload();
    load(1'b0, 1'b1);
    cmd({1'b0, GRP_LISTEN, ADR});
    u_ctrl.send(8'h5a);
    u_ctrl.send(8'h5a);
    cmd({1'b0, CMD_UNL});
    poll(3'b001);
    trig <= 1'b1;
    @(posedge pclk);
    trig <= 1'b0;
    poll(3'b010);
    key <= 1'b1;
    @(posedge pclk);
    key <= 1'b0;
    repeat (10) @(posedge pclk);
    `CHECK("key srq off", 1'b0, srq_oe)
    apb(1'b1, CTRL_OFS, (32'(ADR) << CTRL_ADDR_LSB) | (32'h1 << CTRL_KEYSRQ));
    key <= 1'b1;
    @(posedge pclk);
    key <= 1'b0;
    poll(3'b100);
    stop_test();
  end
endmodule
